// File: aec_checker.sv
// Purpose: Port assertions of aec_counter
// Assumes: Wishbone classic master
// Notes:   Bound to every aec_counter
`timescale 1ns/1ps
module aec_checker (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        high_event_pin,
  input wire logic        low_event_pin,
  input wire logic        event_counter_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [3:0] pin_age_q;
  logic [3:0] wr_age_q;
  logic       mapped;
  assign mapped = wb_adr_i[1:0] == 2'h0 && wb_adr_i[31:18] == 14'h0 &&
                  wb_adr_i[17:2] inside {16'hff95, 16'hff96, 16'hff97, 16'hff98, 16'hfffb};
  // Cycles since pin activity and since a write
  always_ff @(posedge core_clk)
  begin
    pin_age_q <= (reset || pin_age_q == 4'hf) ? 4'hf : pin_age_q + 4'h1;
    wr_age_q  <= (reset || wr_age_q == 4'hf) ? 4'hf : wr_age_q + 4'h1;
    if (!reset && (high_event_pin || low_event_pin)) pin_age_q <= 4'h0;
    if (!reset && wb_we_i && wb_ack_o) wr_age_q <= 4'h0;
  end
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped data");
  a_reset_clear: assert property ($fell(reset) |-> !event_counter_irq && !wb_ack_o) else $error("reset");
  a_irq_rise_cause: assert property ($rose(event_counter_irq) |-> pin_age_q < 4'hc || wr_age_q < 4'h4)
    else $error("irq rise");
  a_irq_fall_cause: assert property ($fell(event_counter_irq) |-> wr_age_q < 4'h4) else $error("irq fall");
  cover property (wb_ack_o && wb_we_i);
  cover property (wb_ack_o && !wb_we_i && !mapped);
  cover property ($rose(event_counter_irq));
endmodule : aec_checker
bind aec_counter aec_checker chk (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .high_event_pin(high_event_pin),
  .low_event_pin(low_event_pin), .event_counter_irq(event_counter_irq));

// File: aec_counter.sv
// Purpose: Asynchronous event counter with Wishbone classic register slave
// Assumes: Event pins are asynchronous and slower than half of core_clk
// Notes:   Pins are sampled by core_clk; rising edges are the events
//
// Contract
// - Split bit zero: halves form one 16-bit counter driven by low pin.
// - In 16-bit mode high half counts low half carry, not its pin.
// - Split bit one: two independent 8-bit counters, each from own pin.
// - Split bit resets to zero, so combined mode after reset.
// - Events from outside are caught regardless of base clocks running; here pins are sampled by core_clk and dropped in standby.
// - Combined counter spans 65536 counts, wrapping all ones to zero.
// - High overflow flag sets whenever high half wraps ff to 00.
// - In combined mode high flag marks full 16-bit wrap.
// - Low overflow flag sets on low wrap only in split mode.
// - Flag clears only after being read as one then written zero.
// - Flag bits accept only zero writes; software cannot set them.
// - Bit 3 enables high counting; zero blocks events, holds value.
// - Bit 2 enables low counting; zero blocks events, holds value.
// - Bit 1 zero holds high half in reset; one releases it.
// - Bit 0 zero holds low half in reset; one releases it.
// - Control/status register resets to 00.
// - Bit 5 is plain read/write storage resetting to zero.
// - Overflow raises an interrupt request to the processor.
// - Module standby stops the block independently of the chip.
// - Clock stop bit 3 zero enters standby, one leaves; resets one.
// - Overflow sets request flag; forwarded only when enable is one.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module aec_counter (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        high_event_pin,
  input  wire logic        low_event_pin,
  output logic             event_counter_irq
);

  aec_pkg::aec_state_type state_q;
  aec_pkg::aec_state_type state_d;

  logic        req_new;
  logic        req_done;
  logic        wr_lane;
  logic [15:0] req_index;
  logic        adr_aligned;
  logic        high_event;
  logic        low_event;
  logic        standby;
  logic        high_inc;
  logic        low_wrap;
  logic        high_wrap;
  logic        high_ovf_set;
  logic        low_ovf_set;
  logic [31:0] read_value;
  logic [7:0]  low_next;
  logic [7:0]  high_next;
  logic        high_flag_next;
  logic        low_flag_next;
  logic        high_armed_next;
  logic        low_armed_next;
  logic        csr_read;
  logic        csr_write;

  assign req_new     = wb_cyc_i & wb_stb_i & ~state_q.ack;
  assign req_done    = wb_cyc_i & wb_stb_i & state_q.ack;
  assign wr_lane     = wb_we_i & wb_sel_i[0];
  assign req_index   = wb_adr_i[17:2];
  assign adr_aligned = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i[31:18] == 14'h0000);

  // Pin synchronisers and rising edge detectors
  aec_edge_detect u_high_edge (
    .core_clk  (core_clk),
    .reset     (reset),
    .event_pin (high_event_pin),
    .rise      (high_event)
  );

  aec_edge_detect u_low_edge (
    .core_clk  (core_clk),
    .reset     (reset),
    .event_pin (low_event_pin),
    .rise      (low_event)
  );

  assign standby = ~state_q.clock_stop[aec_pkg::BIT_STANDBY];

  // Low half counts low pin events when released, enabled and awake
  aec_half_step u_low_half (
    .count      (state_q.count_low),
    .offered    (low_event),
    .enable     (state_q.csr.low_count_enable),
    .run        (state_q.csr.low_reset_release),
    .awake      (~standby),
    .count_next (low_next),
    .step       (),
    .wrap       (low_wrap)
  );

  // High half source selected by the split bit
  always_comb
  begin
    if (state_q.csr.channel_split_select)
    begin
      high_inc = high_event;
    end
    else
    begin
      high_inc = low_wrap;
    end
  end

  aec_half_step u_high_half (
    .count      (state_q.count_high),
    .offered    (high_inc),
    .enable     (state_q.csr.high_count_enable),
    .run        (state_q.csr.high_reset_release),
    .awake      (~standby),
    .count_next (high_next),
    .step       (),
    .wrap       (high_wrap)
  );

  assign high_ovf_set = high_wrap;
  assign low_ovf_set  = low_wrap & state_q.csr.channel_split_select;

  // Flag arming read and clearing write of the control/status register
  assign csr_read  = req_new & ~wb_we_i & adr_aligned & (req_index == aec_pkg::IDX_CTRL_STATUS);
  assign csr_write = req_done & wr_lane & adr_aligned & ~standby & (req_index == aec_pkg::IDX_CTRL_STATUS);

  aec_flag_step u_high_flag (
    .flag       (state_q.csr.high_overflow_flag),
    .armed      (state_q.high_armed),
    .set        (high_ovf_set),
    .read_seen  (csr_read),
    .write_seen (csr_write),
    .write_bit  (wb_dat_i[aec_pkg::BIT_HIGH_OVF]),
    .flag_next  (high_flag_next),
    .armed_next (high_armed_next)
  );

  aec_flag_step u_low_flag (
    .flag       (state_q.csr.low_overflow_flag),
    .armed      (state_q.low_armed),
    .set        (low_ovf_set),
    .read_seen  (csr_read),
    .write_seen (csr_write),
    .write_bit  (wb_dat_i[aec_pkg::BIT_LOW_OVF]),
    .flag_next  (low_flag_next),
    .armed_next (low_armed_next)
  );

  // Read mux
  always_comb
  begin
    read_value = 32'h0000_0000;
    if (adr_aligned)
    begin
      case (req_index)
        aec_pkg::IDX_CTRL_STATUS: read_value = {24'h000000, state_q.csr};
        aec_pkg::IDX_COUNT_HIGH:  read_value = {24'h000000, state_q.count_high};
        aec_pkg::IDX_COUNT_LOW:   read_value = {24'h000000, state_q.count_low};
        aec_pkg::IDX_IRQ_CTRL:    read_value = {30'h0000_0000, state_q.irq_enable, state_q.irq_flag};
        aec_pkg::IDX_CLOCK_STOP:  read_value = {24'h000000, state_q.clock_stop};
        default:                  read_value = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    state_d = state_q;

    // Bus handshake: ack one cycle after request, dropped next
    state_d.ack = req_new;
    if (req_new)
    begin
      state_d.rdata = read_value;
    end

    // Writes take effect at the edge that sees ack
    if (req_done && wr_lane && adr_aligned)
    begin
      case (req_index)
        aec_pkg::IDX_CTRL_STATUS:
        begin
          if (!standby)
          begin
            state_d.csr.reserved_bit         = wb_dat_i[aec_pkg::BIT_RESERVED];
            state_d.csr.channel_split_select = wb_dat_i[aec_pkg::BIT_SPLIT];
            state_d.csr.high_count_enable    = wb_dat_i[aec_pkg::BIT_HIGH_EN];
            state_d.csr.low_count_enable     = wb_dat_i[aec_pkg::BIT_LOW_EN];
            state_d.csr.high_reset_release   = wb_dat_i[aec_pkg::BIT_HIGH_REL];
            state_d.csr.low_reset_release    = wb_dat_i[aec_pkg::BIT_LOW_REL];
          end
        end
        aec_pkg::IDX_IRQ_CTRL:
        begin
          state_d.irq_enable = wb_dat_i[aec_pkg::BIT_IRQ_ENABLE];
          if (!wb_dat_i[aec_pkg::BIT_IRQ_FLAG])
          begin
            state_d.irq_flag = 1'b0;
          end
        end
        aec_pkg::IDX_CLOCK_STOP:
        begin
          state_d.clock_stop = wb_dat_i[7:0];
        end
        default:
        begin
          state_d.clock_stop = state_d.clock_stop;
        end
      endcase
    end

    // Counters; reset release low forces zero
    state_d.count_low  = low_next;
    state_d.count_high = high_next;

    // Flags and their arming; hardware set wins inside the flag step
    state_d.csr.high_overflow_flag = high_flag_next;
    state_d.csr.low_overflow_flag  = low_flag_next;
    state_d.high_armed             = high_armed_next;
    state_d.low_armed              = low_armed_next;
    if (high_ovf_set || low_ovf_set)
    begin
      state_d.irq_flag = 1'b1;
    end

    state_d.irq = state_d.irq_flag & state_d.irq_enable;

    // Synchronous system reset
    if (reset)
    begin
      state_d.csr        = aec_pkg::RST_CTRL_STATUS;
      state_d.count_high = aec_pkg::RST_COUNT;
      state_d.count_low  = aec_pkg::RST_COUNT;
      state_d.high_armed = 1'b0;
      state_d.low_armed  = 1'b0;
      state_d.irq_flag   = 1'b0;
      state_d.irq_enable = 1'b0;
      state_d.irq        = 1'b0;
      state_d.clock_stop = aec_pkg::RST_CLOCK_STOP;
      state_d.ack        = 1'b0;
      state_d.rdata      = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    state_q <= state_d;
  end

  assign wb_dat_o          = state_q.rdata;
  assign wb_ack_o          = state_q.ack;
  assign event_counter_irq = state_q.irq;

endmodule : aec_counter

// Two-stage pin synchroniser with rising edge detector
module aec_edge_detect (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic event_pin,
  output logic      rise
);

  aec_pkg::aec_pin_type state_q;
  aec_pkg::aec_pin_type state_d;

  always_comb
  begin
    state_d      = state_q;
    state_d.meta = event_pin;
    state_d.sync = state_q.meta;
    state_d.last = state_q.sync;
    // Stages preset high so a pin high at release gives no edge
    if (reset)
    begin
      state_d = '1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    state_q <= state_d;
  end

  // Only the second stage and its copy feed the edge
  assign rise = state_q.sync & ~state_q.last;

endmodule : aec_edge_detect

// Next value and wrap of one 8-bit counter half
module aec_half_step (
  input  wire logic [7:0] count,
  input  wire logic       offered,
  input  wire logic       enable,
  input  wire logic       run,
  input  wire logic       awake,
  output logic      [7:0] count_next,
  output logic            step,
  output logic            wrap
);

  always_comb
  begin
    step       = offered & enable & run & awake;
    wrap       = step & (count == aec_pkg::COUNT_MAX);
    count_next = count;
    if (!run)
    begin
      count_next = aec_pkg::RST_COUNT;
    end
    else if (step)
    begin
      count_next = count + aec_pkg::COUNT_ONE;
    end
  end

endmodule : aec_half_step

// Overflow flag with read-arm and zero-write clear
module aec_flag_step (
  input  wire logic flag,
  input  wire logic armed,
  input  wire logic set,
  input  wire logic read_seen,
  input  wire logic write_seen,
  input  wire logic write_bit,
  output logic      flag_next,
  output logic      armed_next
);

  always_comb
  begin
    flag_next  = flag;
    armed_next = armed;
    if (read_seen && flag)
    begin
      armed_next = 1'b1;
    end
    if (write_seen)
    begin
      // Only a zero after an armed read clears; a one keeps the flag but disarms it
      if (!write_bit && armed)
      begin
        flag_next = 1'b0;
      end
      armed_next = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (set)
    begin
      flag_next = 1'b1;
    end
  end

endmodule : aec_flag_step

// File: aec_event_src.sv
// Purpose: Event source model for the pins
// Assumes: Pins idle low between bursts
// Notes:   Edges kept off core_clk edges
`timescale 1ns/1ps
module aec_event_src (
  output logic high_event_pin,
  output logic low_event_pin
);
  initial
  begin
    high_event_pin = 1'b0;
    low_event_pin  = 1'b0;
  end
  task automatic burst(input logic h, input logic l, input int k, input int slow);
    #7;
    repeat (k)
    begin
      high_event_pin = h;
      low_event_pin  = l;
      #(100 * slow);
      high_event_pin = 1'b0;
      low_event_pin  = 1'b0;
      #(100 * slow);
    end
  endtask : burst
endmodule : aec_event_src

// File: aec_pkg.sv
// Purpose: Shared constants and types of the asynchronous event counter
// Assumes: Wishbone classic, 32-bit data, one register per aligned word
// Notes:   Byte address of a register is four times its index
package aec_pkg;

  // Register indices; byte address is index times four
  localparam logic [15:0] IDX_CTRL_STATUS = 16'hff95;
  localparam logic [15:0] IDX_COUNT_HIGH  = 16'hff96;
  localparam logic [15:0] IDX_COUNT_LOW   = 16'hff97;
  localparam logic [15:0] IDX_IRQ_CTRL    = 16'hff98;
  localparam logic [15:0] IDX_CLOCK_STOP  = 16'hfffb;
  localparam int          ADR_SHIFT       = 2;

  // Control/status field positions
  localparam int BIT_HIGH_OVF    = 7;
  localparam int BIT_LOW_OVF     = 6;
  localparam int BIT_RESERVED    = 5;
  localparam int BIT_SPLIT       = 4;
  localparam int BIT_HIGH_EN     = 3;
  localparam int BIT_LOW_EN      = 2;
  localparam int BIT_HIGH_REL    = 1;
  localparam int BIT_LOW_REL     = 0;

  // Clock stop field position
  localparam int BIT_STANDBY     = 3;

  // Interrupt control field positions
  localparam int BIT_IRQ_FLAG    = 0;
  localparam int BIT_IRQ_ENABLE  = 1;

  // Reset values and counter constants
  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [7:0] RST_CLOCK_STOP  = 8'hff;
  localparam logic [7:0] RST_COUNT       = 8'h00;
  localparam logic [7:0] COUNT_MAX       = 8'hff;
  localparam logic [7:0] COUNT_ONE       = 8'h01;

  // Pin synchroniser and edge detector
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } aec_pin_type;

  // Software-visible control bits
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic reserved_bit;
    logic channel_split_select;
    logic high_count_enable;
    logic low_count_enable;
    logic high_reset_release;
    logic low_reset_release;
  } aec_csr_type;

  // Whole state of the counter block
  typedef struct packed {
    aec_csr_type csr;
    logic [7:0]  count_high;
    logic [7:0]  count_low;
    logic        high_armed;
    logic        low_armed;
    logic        irq_flag;
    logic        irq_enable;
    logic        irq;
    logic [7:0]  clock_stop;
    logic        ack;
    logic [31:0] rdata;
  } aec_state_type;

endpackage : aec_pkg

// File: tb.sv
// Purpose: Self-checking bench of aec_counter
// Assumes: Partner drives the event pins
// Notes:   Random counts from seed 55
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        cyc      = 1'b0;
  logic        we       = 1'b0;
  logic [31:0] adr      = 32'h0;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        hp;
  logic        lp;
  logic [7:0]  r;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          seed       = 55;
  int          n;
  int          m;
  always #12.5 core_clk = ~core_clk;
  aec_counter uut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .high_event_pin(hp), .low_event_pin(lp), .event_counter_irq(irq));
  aec_event_src src (.high_event_pin(hp), .low_event_pin(lp));
  function automatic logic [7:0] cnt8(input int v);
    return v[7:0];
  endfunction : cnt8
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {14'h0, idx, 2'h0};
    wdat <= {24'h0, d};
    @(posedge core_clk);
    while (ack !== 1'b1 && t < 20)
    begin
      @(posedge core_clk);
      t++;
    end
    if (t == 20) n_mismatch++;
    r = rdat[7:0];
    cyc <= 1'b0;
    @(posedge core_clk);
  endtask : xfer
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(r, exp);
  endtask : rd
  task automatic ev(input logic h, input logic l, input int k, input int slow);
    src.burst(h, l, k, slow);
    repeat (6) @(posedge core_clk);
  endtask : ev
  task automatic end_of_test;
    $display("Tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    end_of_test;
  end
  initial
  begin
    n = 1 + ($unsigned($random(seed)) % 40);
    m = 1 + ($unsigned($random(seed)) % 40);
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(16'hff95, 8'h00);
    rd(16'hff97, 8'h00);
    rd(16'hfffb, 8'hff);
    xfer(1'b1, 16'hff95, 8'he0);
    rd(16'hff95, 8'h20);
    xfer(1'b1, 16'hff95, 8'h2f);
    ev(1'b1, 1'b1, n, 1);
    rd(16'hff97, cnt8(n));
    rd(16'hff96, 8'h00);
    ev(1'b0, 1'b1, 256, 1);
    rd(16'hff96, 8'h01);
    rd(16'hff95, 8'h2f);
    xfer(1'b1, 16'hff95, 8'h2b);
    ev(1'b0, 1'b1, 5, 2);
    rd(16'hff97, cnt8(n));
    xfer(1'b1, 16'hff95, 8'h2e);
    rd(16'hff97, 8'h00);
    xfer(1'b1, 16'hff95, 8'h3d);
    rd(16'hff96, 8'h00);
    xfer(1'b1, 16'hff95, 8'h37);
    ev(1'b1, 1'b0, 3, 1);
    rd(16'hff96, 8'h00);
    xfer(1'b1, 16'hff95, 8'h3f);
    ev(1'b1, 1'b0, m, 1);
    rd(16'hff96, cnt8(m));
    ev(1'b1, 1'b1, 256, 1);
    chk({7'h0, irq}, 8'h00);
    xfer(1'b1, 16'hff95, 8'h3f);
    rd(16'hff95, 8'hff);
    xfer(1'b1, 16'hff95, 8'h3f);
    rd(16'hff95, 8'h3f);
    xfer(1'b1, 16'hff98, 8'h03);
    repeat (2) @(posedge core_clk);
    chk({7'h0, irq}, 8'h01);
    rd(16'hff98, 8'h03);
    xfer(1'b1, 16'hff98, 8'h02);
    repeat (2) @(posedge core_clk);
    chk({7'h0, irq}, 8'h00);
    xfer(1'b1, 16'hfffb, 8'hf7);
    xfer(1'b1, 16'hff95, 8'h00);
    ev(1'b1, 1'b1, 4, 1);
    rd(16'hff96, cnt8(m));
    rd(16'hff95, 8'h3f);
    n = $random(seed) | 8;
    xfer(1'b1, 16'hfffb, n[7:0]);
    rd(16'hfffb, n[7:0]);
    ev(1'b1, 1'b0, 2, 2);
    rd(16'hff96, cnt8(m + 2));
    rd(16'hff99, 8'h00);
    end_of_test;
  end
endmodule : tb
